// ===== i2c_master_seq.sv
// Purpose: Master start, repeated start, stop and byte transmit sequencer with rate counter.
// Assumes: Open-drain lines; an enable high pulls the line low; the bench resolves the wire.
// Notes: Requests are taken only while idle; nothing queues behind a running bus event.
//
// Functional notes
// R01 - Transmit: software loads address with direction 0, then bytes; ack follows each.
// R02 - Receive use: address byte with direction 1 goes out the same way.
// R03 - Slave ack is stored in control register; flag set at ninth clock end.
// R04 - Rate counter reloads from low seven reload bits at each bus phase.
// R05 - Buffer write starts the counter; it counts to zero then halts.
// R06 - Counter decrements on second and fourth phase of each instruction cycle.
// R07 - When an operation ends the counter stops and SCL keeps its level.
// R08 - One SCL period is two rollovers of reload plus one half cycles.
// R09 - Released SCL suspends the counter until sampled high, then reload.
// R10 - Start: both lines high, count; still high at timeout, pull SDA low.
// R11 - Start: count again; on timeout clear request, halt, hold SDA low.
// R12 - Start collision: both low at outset or SCL low early; abort to idle.
// R13 - Buffer write during start sets write collision, buffer unchanged.
// R14 - Low five control bits ignored while a start or restart runs.
// R15 - Restart: pull SCL low; once low, load short reload, release SDA.
// R16 - Restart: release SCL, both high a period, SDA low a period, done.
// R17 - Restart: start seen on the lines at once; port flag at final timeout.
// R18 - Restart request written during any other event is ignored.
// R19 - Restart collision: SDA low as SCL rises, or SCL falls too early.
// R20 - Buffer write during restart sets write collision, buffer unchanged.
// R21 - Software writes address after restart flag, then next byte after ack.
// R22 - Software: start, wait flag, address, data after each ack, then stop.
// R23 - Stop: SDA low, period, release SCL, period, release SDA, period, flag.
// R24 - Requests accepted only while idle; one bus event at a time.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module i2c_master_seq
    import i2c_seq_pkg::*;
(
    // Clock, reset and freeze.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register port.
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Bus lines, open drain.
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);
    seq_regs_s r;
    seq_regs_s n;
    logic tick;
    logic timeout;
    logic scl_s;
    logic sda_s;
    logic [6:0] rate_lo;

    // Rate ticks fall on the second and fourth phase; timeout is a tick at zero.
    assign tick = (r.phase == PHASE_SECOND) || (r.phase == PHASE_FOURTH); // R06
    assign timeout = tick && r.run && (r.cnt == 7'h00);
    assign scl_s = r.scl.s2;
    assign sda_s = r.sda.s2;
    assign rate_lo = r.rate[RATE_HI:0];

    // Next-state logic for the whole block.
    always_comb begin
        n = r;
        n.phase = r.phase + 2'h1;
        // Line synchronisers; only the second stage and its history are read.
        n.scl.s1 = scl_i;
        n.scl.s2 = r.scl.s1;
        n.scl.d = r.scl.s2;
        n.sda.s1 = sda_i;
        n.sda.s2 = r.sda.s1;
        n.sda.d = r.sda.s2;
        // Count down on each tick, halt once zero is reached.
        if (tick && r.run) begin
            if (r.cnt != 7'h00) begin
                n.cnt = r.cnt - 7'h01; // R06
            end else begin
                n.run = 1'b0; // R05
            end
        end
        // Start and stop conditions seen on the lines.
        if (r.scl.d && scl_s && r.sda.d && !sda_s) begin
            n.start_seen = 1'b1; // R10 R17
            n.stop_seen = 1'b0;
        end
        if (r.scl.d && scl_s && !r.sda.d && sda_s) begin
            n.stop_seen = 1'b1; // R23
            n.start_seen = 1'b0;
        end
        // Read data stands only in the cycle after the strobe.
        n.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                ADDR_BUFFER: n.rdata = r.buffer;
                ADDR_CONTROL: begin
                    n.rdata[CTL_START] = r.start_request_bit;
                    n.rdata[CTL_RESTART] = r.restart_request_bit;
                    n.rdata[CTL_STOP] = r.stop_request_bit;
                    n.rdata[CTL_ACKSTAT] = r.ackstat;
                end
                ADDR_RATE: n.rdata = r.rate;
                ADDR_STATUS: begin
                    n.rdata[STS_FULL] = r.full;
                    n.rdata[STS_START] = r.start_seen;
                    n.rdata[STS_STOP] = r.stop_seen;
                end
                ADDR_FLAGS: begin
                    n.rdata[FLG_PORT] = r.pif;
                    n.rdata[FLG_BUSCOL] = r.bcol;
                    n.rdata[FLG_WRCOL] = r.write_collision_flag;
                end
                default: n.rdata = 8'h00;
            endcase
        end
        // Software writes; flag clears come first so later hardware sets win.
        if (wr_i) begin
            case (addr_i)
                ADDR_FLAGS: begin
                    if (wdata_i[FLG_PORT]) n.pif = 1'b0;
                    if (wdata_i[FLG_BUSCOL]) n.bcol = 1'b0;
                    if (wdata_i[FLG_WRCOL]) n.write_collision_flag = 1'b0;
                end
                ADDR_RATE: n.rate = wdata_i;
                ADDR_BUFFER: begin
                    if (r.state == S_IDLE) begin
                        // First bit goes out with SCL pulled low.
                        n.buffer = wdata_i; // R01 R02
                        n.full = 1'b1;
                        n.shifter = {wdata_i[6:0], 1'b0};
                        n.sda_oe = ~wdata_i[7];
                        n.scl_oe = 1'b1;
                        n.bitcnt = 4'h0;
                        n.cnt = rate_lo; // R05
                        n.run = 1'b1;
                        n.state = S_TX_LOW;
                    end else begin
                        n.write_collision_flag = 1'b1; // R13 R20
                    end
                end
                ADDR_CONTROL: begin
                    // Requests count only in idle, highest priority first.
                    if (r.state == S_IDLE) begin // R14 R18 R24
                        if (wdata_i[CTL_START]) begin
                            if (scl_s && sda_s) begin
                                n.start_request_bit = 1'b1;
                                n.cnt = rate_lo; // R10
                                n.run = 1'b1;
                                n.state = S_ST_WAIT;
                            end else if (!scl_s && !sda_s) begin
                                n.bcol = 1'b1; // R12
                            end
                        end else if (wdata_i[CTL_RESTART]) begin
                            n.restart_request_bit = 1'b1;
                            n.scl_oe = 1'b1; // R15
                            n.state = S_RS_PULL;
                        end else if (wdata_i[CTL_STOP]) begin
                            n.stop_request_bit = 1'b1;
                            n.sda_oe = 1'b1; // R23
                            n.state = S_SP_SDALO;
                        end
                    end
                end
                default: ;
            endcase
        end
        // Sequencer proper.
        case (r.state)
            S_IDLE: ;
            S_ST_WAIT: begin
                if (!scl_s) begin
                    n.bcol = 1'b1; // R12
                    n.start_request_bit = 1'b0;
                    n.run = 1'b0;
                    n.state = S_IDLE;
                end else if (timeout) begin
                    n.sda_oe = 1'b1; // R10
                    n.cnt = rate_lo; // R11
                    n.run = 1'b1;
                    n.state = S_ST_HOLD;
                end
            end
            S_ST_HOLD: begin
                if (timeout) begin
                    n.start_request_bit = 1'b0; // R11
                    n.run = 1'b0;
                    n.pif = 1'b1;
                    n.state = S_IDLE;
                end
            end
            S_RS_PULL: begin
                if (!scl_s) begin
                    n.cnt = {1'b0, r.rate[RESTART_HI:0]}; // R15
                    n.run = 1'b1;
                    n.sda_oe = 1'b0;
                    n.state = S_RS_SDAHI;
                end
            end
            S_RS_SDAHI: begin
                if (timeout) begin
                    if (sda_s) begin
                        n.scl_oe = 1'b0; // R16
                        n.state = S_RS_SCLREL;
                    end else begin
                        n.bcol = 1'b1; // R19
                        n.restart_request_bit = 1'b0;
                        n.state = S_IDLE;
                    end
                end
            end
            S_RS_SCLREL: begin
                // Counter waits here while another party stretches SCL.
                if (scl_s) begin
                    if (!sda_s) begin
                        n.bcol = 1'b1; // R19
                        n.restart_request_bit = 1'b0;
                        n.state = S_IDLE;
                    end else begin
                        n.cnt = rate_lo; // R09 R16
                        n.run = 1'b1;
                        n.state = S_RS_BOTHHI;
                    end
                end
            end
            S_RS_BOTHHI: begin
                if (!scl_s) begin
                    n.bcol = 1'b1; // R19
                    n.restart_request_bit = 1'b0;
                    n.run = 1'b0;
                    n.state = S_IDLE;
                end else if (timeout) begin
                    n.sda_oe = 1'b1; // R16
                    n.cnt = rate_lo;
                    n.run = 1'b1;
                    n.state = S_RS_SDALO;
                end
            end
            S_RS_SDALO: begin
                if (timeout) begin
                    n.restart_request_bit = 1'b0; // R16
                    n.run = 1'b0;
                    n.pif = 1'b1; // R17
                    n.state = S_IDLE;
                end
            end
            S_TX_LOW: begin
                if (timeout) begin
                    n.scl_oe = 1'b0; // R08
                    n.state = S_TX_REL;
                end
            end
            S_TX_REL: begin
                if (scl_s) begin
                    n.cnt = rate_lo; // R04 R09
                    n.run = 1'b1;
                    n.state = S_TX_HIGH;
                end
            end
            S_TX_HIGH: begin
                if (timeout) begin
                    n.scl_oe = 1'b1;
                    if (r.bitcnt == ACK_BIT) begin
                        n.ackstat = sda_s; // R03
                        n.pif = 1'b1;
                        n.run = 1'b0; // R07
                        n.state = S_IDLE;
                    end else begin
                        n.bitcnt = r.bitcnt + 4'h1;
                        n.cnt = rate_lo; // R04
                        n.run = 1'b1;
                        n.state = S_TX_LOW;
                        if (r.bitcnt + 4'h1 == ACK_BIT) begin
                            n.sda_oe = 1'b0; // R01
                            n.full = 1'b0;
                        end else begin
                            n.sda_oe = ~r.shifter[7];
                            n.shifter = {r.shifter[6:0], 1'b0};
                        end
                    end
                end
            end
            S_SP_SDALO: begin
                if (!sda_s) begin
                    n.cnt = rate_lo; // R23
                    n.run = 1'b1;
                    n.state = S_SP_CNT1;
                end
            end
            S_SP_CNT1: begin
                if (timeout) begin
                    n.scl_oe = 1'b0; // R23
                    n.state = S_SP_SCLREL;
                end
            end
            S_SP_SCLREL: begin
                if (scl_s) begin
                    n.cnt = rate_lo; // R09
                    n.run = 1'b1;
                    n.state = S_SP_CNT2;
                end
            end
            S_SP_CNT2: begin
                if (timeout) begin
                    n.sda_oe = 1'b0; // R23
                    n.cnt = rate_lo;
                    n.run = 1'b1;
                    n.state = S_SP_CNT3;
                end
            end
            S_SP_CNT3: begin
                if (timeout) begin
                    n.stop_request_bit = 1'b0; // R23
                    n.pif = 1'b1;
                    n.run = 1'b0;
                    n.state = S_IDLE;
                end
            end
            default: n = REGS_RESET;
        endcase
    end

    // State register; a low clock enable freezes everything.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= REGS_RESET;
        end else if (ce_i) begin
            r <= n;
        end
    end

    // Outputs straight from the state record; the low level is always driven.
    assign rdata_o = r.rdata;
    assign scl_oe_o = r.scl_oe;
    assign sda_oe_o = r.sda_oe;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    // Assertions.
    property p_reload_on_high;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && r.state == S_TX_REL && scl_s) |=> (r.cnt == $past(rate_lo) && r.run);
    endproperty
    a_reload_on_high: assert property (p_reload_on_high) // R04
        else $error("Counter not reloaded when SCL seen high.");

    property p_decrement;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && r.state == S_TX_LOW && tick && r.run && r.cnt != 7'h00 && !timeout)
            |=> (r.cnt == $past(r.cnt) - 7'h01);
    endproperty
    a_decrement: assert property (p_decrement) // R06
        else $error("Counter did not step down on a tick.");

    property p_stretch_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && r.state == S_TX_REL && !scl_s) |=> ($stable(r.cnt) && !r.run);
    endproperty
    a_stretch_hold: assert property (p_stretch_hold) // R09
        else $error("Counter moved while SCL held low.");

    property p_start_collision;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && r.state == S_ST_WAIT && !scl_s) |=> (r.bcol && !r.start_request_bit && r.state == S_IDLE);
    endproperty
    a_start_collision: assert property (p_start_collision) // R12
        else $error("Start collision not flagged.");

    property p_start_done;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && r.state == S_ST_HOLD && timeout) |=> (!r.start_request_bit && r.sda_oe && r.pif && !r.run);
    endproperty
    a_start_done: assert property (p_start_done) // R11
        else $error("Start did not complete properly.");

    property p_write_collision_flag;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && wr_i && addr_i == ADDR_BUFFER && r.state != S_IDLE)
            |=> (r.write_collision_flag && $stable(r.buffer));
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) // R13
        else $error("Busy buffer write not refused.");

    property p_no_queue;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && wr_i && addr_i == ADDR_CONTROL && r.state != S_IDLE && !r.stop_request_bit) |=> !r.stop_request_bit;
    endproperty
    a_no_queue: assert property (p_no_queue) // R14
        else $error("Request taken while busy.");

    property p_restart_done;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && r.state == S_RS_SDALO && timeout) |=> (!r.restart_request_bit && r.sda_oe && r.pif);
    endproperty
    a_restart_done: assert property (p_restart_done) // R16
        else $error("Restart did not complete properly.");

    property p_ack_store;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && r.state == S_TX_HIGH && timeout && r.bitcnt == ACK_BIT)
            |=> (r.pif && r.ackstat == $past(sda_s) && r.scl_oe && !r.run);
    endproperty
    a_ack_store: assert property (p_ack_store) // R03
        else $error("Acknowledge not stored at ninth clock.");
endmodule : i2c_master_seq

// ===== i2c_master_seq_tb_top.sv
// Purpose: Self-checking bench for the master start, restart, byte and stop sequencer.
// Assumes: Rate reload 9 gives an SCL period near 160 ns at a 4 ns clock.
// Notes: Each scenario is one task; waits are bounded and end the run when they run out.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR at %0t: got %h expected %h", $time, (a), (b)); end end
module i2c_master_seq_tb_top;
    import i2c_seq_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic scl_oe_o, sda_oe_o, slv_scl, slv_sda, tb_low = 1'b0, tb_scl = 1'b0, stretch = 1'b0;
    logic scl_lv, sda_lv;
    logic [7:0] slv_byte;
    logic [7:0] d;
    int err_total = 0;
    int n_tests = 0;
    int hi_cnt = 0;
    int last_hi = 0;
    // Open-drain wires with pull-ups.
    wire scl = ~(scl_oe_o | slv_scl | tb_low | tb_scl);
    wire sda = ~(sda_oe_o | slv_sda | tb_low);

    i2c_master_seq i_i2c_master_seq (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .scl_i(scl), .scl_o(scl_lv), .scl_oe_o(scl_oe_o),
        .sda_i(sda), .sda_o(sda_lv), .sda_oe_o(sda_oe_o));
    i2c_slave_model i_i2c_slave_model (.scl_i(scl), .sda_i(sda), .stretch_i(stretch),
        .scl_low_o(slv_scl), .sda_low_o(slv_sda), .last_byte_o(slv_byte));

    // Clock generator.
    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // Measures the length of each SCL high phase in clocks.
    always @(posedge ref_clk_i) begin
        if (scl) begin
            hi_cnt <= hi_cnt + 1;
        end else if (hi_cnt != 0) begin
            last_hi <= hi_cnt;
            hi_cnt <= 0;
        end
    end

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : rd

    // Polls the port flag; the flags are left set for the caller to clear.
    task automatic wait_flag();
        int i;
        for (i = 0; i < 3000; i++) begin
            rd(ADDR_FLAGS, d);
            if (d[FLG_PORT] === 1'b1) break;
        end
        if (i == 3000) begin
            err_total++;
            $display("ERROR at %0t: port flag never set", $time);
            end_sim();
        end
    endtask : wait_flag

    task automatic t_reset_values();
        rd(ADDR_STATUS, d); `CHK(d, 8'h00)
        rd(ADDR_FLAGS, d); `CHK(d, 8'h00)
        rd(ADDR_RATE, d); `CHK(d, RATE_RESET)
        rd(8'h14, d); `CHK(d, 8'h00)
        wr(ADDR_RATE, 8'h89);
        rd(ADDR_RATE, d); `CHK(d, 8'h89)
    endtask : t_reset_values

    task automatic t_start();
        wr(ADDR_CONTROL, 8'h01);
        wr(ADDR_BUFFER, 8'h77);
        wr(ADDR_CONTROL, 8'h04);
        wait_flag();
        `CHK(d[FLG_WRCOL], 1'b1)
        `CHK(sda_oe_o, 1'b1)
        `CHK({scl_lv, sda_lv}, 2'b00)
        wr(ADDR_FLAGS, 8'h07);
        rd(ADDR_STATUS, d); `CHK(d[STS_START], 1'b1)
        rd(ADDR_CONTROL, d); `CHK(d[2:0], 3'h0)
    endtask : t_start

    task automatic t_byte(input logic [7:0] v, input logic ack, input logic busy_wr);
        wr(ADDR_BUFFER, v);
        if (busy_wr) begin
            wr(ADDR_CONTROL, 8'h02);
            wr(ADDR_BUFFER, ~v);
        end
        wait_flag();
        if (busy_wr) `CHK(d[FLG_WRCOL], 1'b1)
        wr(ADDR_FLAGS, 8'h07);
        `CHK(slv_byte, v)
        `CHK(scl_oe_o, 1'b1)
        rd(ADDR_CONTROL, d); `CHK(d[CTL_ACKSTAT], ack)
        `CHK(d[2:0], 3'h0)
        rd(ADDR_STATUS, d); `CHK(d[STS_FULL], 1'b0)
    endtask : t_byte

    task automatic t_restart();
        wr(ADDR_CONTROL, 8'h02);
        wr(ADDR_BUFFER, 8'h11);
        wait_flag();
        `CHK(d[FLG_WRCOL], 1'b1)
        wr(ADDR_FLAGS, 8'h07);
        `CHK(sda_oe_o, 1'b1)
        rd(ADDR_STATUS, d); `CHK(d[STS_START], 1'b1)
        rd(ADDR_CONTROL, d); `CHK(d[CTL_RESTART], 1'b0)
    endtask : t_restart

    task automatic t_stop();
        wr(ADDR_CONTROL, 8'h04);
        wait_flag();
        wr(ADDR_FLAGS, 8'h07);
        `CHK({scl, sda}, 2'b11)
        rd(ADDR_STATUS, d); `CHK(d[STS_STOP], 1'b1)
        rd(ADDR_CONTROL, d); `CHK(d[CTL_STOP], 1'b0)
    endtask : t_stop

    task automatic t_collision();
        tb_low <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        wr(ADDR_CONTROL, 8'h01);
        repeat (40) @(posedge ref_clk_i);
        rd(ADDR_FLAGS, d); `CHK(d[FLG_BUSCOL], 1'b1)
        `CHK(sda_oe_o, 1'b0)
        rd(ADDR_CONTROL, d); `CHK(d[CTL_START], 1'b0)
        tb_low <= 1'b0;
        wr(ADDR_FLAGS, 8'h07);
        // SCL pulled low by another party before SDA is driven low aborts the start.
        repeat (4) @(posedge ref_clk_i);
        wr(ADDR_CONTROL, 8'h01);
        tb_scl <= 1'b1;
        repeat (40) @(posedge ref_clk_i);
        rd(ADDR_FLAGS, d); `CHK(d[FLG_BUSCOL], 1'b1)
        `CHK(sda_oe_o, 1'b0)
        rd(ADDR_CONTROL, d); `CHK(d[CTL_START], 1'b0)
        tb_scl <= 1'b0;
        wr(ADDR_FLAGS, 8'h07);
    endtask : t_collision

    // Main sequence.
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        t_reset_values();
        t_start();
        t_byte(8'ha0, 1'b0, 1'b1);
        `CHK((last_hi >= 20 && last_hi <= 28), 1'b1)
        stretch <= 1'b1;
        t_byte(8'h3c, 1'b0, 1'b0);
        stretch <= 1'b0;
        `CHK((last_hi >= 20 && last_hi <= 28), 1'b1)
        t_stop();
        t_restart();
        t_byte(8'hb1, 1'b1, 1'b0);
        t_stop();
        t_collision();
        end_sim();
    end
endmodule : i2c_master_seq_tb_top

// ===== i2c_seq_pkg.sv
// Purpose: Shared constants, states and state record of the master start/restart sequencer.
// Assumes: One register word per byte address step of four, eight data bits each.
// Notes: Four reference clocks form one instruction cycle; the rate counter ticks twice in it.
package i2c_seq_pkg;
    // Register byte addresses.
    localparam logic [7:0] ADDR_BUFFER = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_RATE = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_FLAGS = 8'h10;
    // Second control register fields.
    localparam int CTL_START = 0;
    localparam int CTL_RESTART = 1;
    localparam int CTL_STOP = 2;
    localparam int CTL_ACKSTAT = 6;
    // Port status register fields.
    localparam int STS_FULL = 0;
    localparam int STS_START = 3;
    localparam int STS_STOP = 4;
    // Event flag register fields, cleared by writing a one.
    localparam int FLG_PORT = 0;
    localparam int FLG_BUSCOL = 1;
    localparam int FLG_WRCOL = 2;
    // Reload field tops: full reload and the shorter restart reload.
    localparam int RATE_HI = 6;
    localparam int RESTART_HI = 5;
    // Phase counter values that tick the rate counter.
    localparam logic [1:0] PHASE_SECOND = 2'h1;
    localparam logic [1:0] PHASE_FOURTH = 2'h3;
    // Index of the acknowledge bit within a byte slot.
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [7:0] RATE_RESET = 8'h00;

    typedef enum logic [15:0] {
        S_IDLE = 16'h0001, S_ST_WAIT = 16'h0002, S_ST_HOLD = 16'h0004,
        S_RS_PULL = 16'h0008, S_RS_SDAHI = 16'h0010, S_RS_SCLREL = 16'h0020,
        S_RS_BOTHHI = 16'h0040, S_RS_SDALO = 16'h0080, S_TX_LOW = 16'h0100,
        S_TX_REL = 16'h0200, S_TX_HIGH = 16'h0400, S_SP_SDALO = 16'h0800,
        S_SP_CNT1 = 16'h1000, S_SP_SCLREL = 16'h2000, S_SP_CNT2 = 16'h4000,
        S_SP_CNT3 = 16'h8000
    } seq_state_e;

    // Two-stage synchroniser plus one history stage for one bus line.
    typedef struct packed {
        logic s1;
        logic s2;
        logic d;
    } line_sync_s;

    typedef struct packed {
        seq_state_e state;
        logic [6:0] cnt;
        logic run;
        logic [1:0] phase;
        logic [7:0] buffer;
        logic [7:0] shifter;
        logic [3:0] bitcnt;
        logic full;
        logic start_request_bit;
        logic restart_request_bit;
        logic stop_request_bit;
        logic ackstat;
        logic start_seen;
        logic stop_seen;
        logic pif;
        logic bcol;
        logic write_collision_flag;
        logic [7:0] rate;
        logic scl_oe;
        logic sda_oe;
        logic [7:0] rdata;
        line_sync_s scl;
        line_sync_s sda;
    } seq_regs_s;

    localparam seq_regs_s REGS_RESET = '{
        state: S_IDLE, cnt: 7'h00, run: 1'b0, phase: 2'h0, buffer: 8'h00,
        shifter: 8'h00, bitcnt: 4'h0, full: 1'b0, start_request_bit: 1'b0, restart_request_bit: 1'b0,
        stop_request_bit: 1'b0, ackstat: 1'b0, start_seen: 1'b0, stop_seen: 1'b0,
        pif: 1'b0, bcol: 1'b0, write_collision_flag: 1'b0, rate: RATE_RESET, scl_oe: 1'b0,
        sda_oe: 1'b0, rdata: 8'h00, scl: 3'h7, sda: 3'h7
    };
endpackage : i2c_seq_pkg

// ===== i2c_slave_model.sv
// Purpose: Behavioural slave on the bus that acks its own address and may stretch the clock.
// Assumes: Both wires have pull-ups; an output high pulls its wire low.
// Notes: Stretching holds SCL low for a fixed 200 ns after every falling edge.
`timescale 1ns/1ps
module i2c_slave_model #(
    parameter logic [6:0] DEV_ADDR = 7'h50
) (
    // Wire levels and stretch control.
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic stretch_i,
    // Pull-low drives and the last byte seen.
    output logic scl_low_o,
    output logic sda_low_o,
    output logic [7:0] last_byte_o
);
    logic [7:0] sh;
    int n;
    logic first;
    logic sel;

    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
        last_byte_o = 8'h00;
        sh = 8'h00;
        n = 0;
        first = 1'b0;
        sel = 1'b0;
    end

    // A falling SDA while SCL is high opens a new frame.
    always @(negedge sda_i) begin
        if (scl_i) begin
            n = 0;
            first = 1'b1;
            sel = 1'b0;
        end
    end

    // Data is taken on the rising clock; the ninth clock carries the ack.
    always @(posedge scl_i) begin
        if (n < 8) begin
            sh = {sh[6:0], sda_i};
            n = n + 1;
        end else begin
            n = 0;
        end
    end

    // The ack is driven after the eighth fall and dropped after the ninth.
    always @(negedge scl_i) begin
        if (n == 8) begin
            last_byte_o = sh;
            if (first) begin
                sel = (sh[7:1] == DEV_ADDR);
            end
            first = 1'b0;
            sda_low_o = sel;
        end else begin
            sda_low_o = 1'b0;
        end
        if (stretch_i) begin
            scl_low_o = 1'b1;
            #200;
            scl_low_o = 1'b0;
        end
    end
endmodule : i2c_slave_model
